// ### include/amv_pkg.sv
`default_nettype none
package amv_pkg;
    // command codes and selector bytes
    localparam logic [7:0] CMD_ALERT_MASK   = 8'h1B;
    localparam logic [7:0] CMD_VOUT_FORMAT  = 8'h20;
    localparam logic [7:0] SEL_OTHER_STATUS = 8'h7F;
    localparam logic [7:0] SEL_VENDOR       = 8'h80;

    // other-status mask: only bit 0, fixed at 1
    localparam logic [7:0] OTHER_MASK_VALUE = 8'h01;

    // vendor-status mask field positions
    localparam int POWER_ON_EVENT_BIT = 7;
    localparam int SELF_CHECK_BIT     = 6;
    localparam int RESET_PIN_BIT      = 3;
    localparam int STACK_LINK_BIT     = 2;
    localparam int SYNC_FAULT_BIT     = 1;
    localparam logic [7:0] VENDOR_WRITABLE = 8'hCE;
    localparam logic [7:0] VENDOR_MASK_RESET = 8'hCE;

    // output-voltage format byte layout
    localparam int REL_BIT  = 7;
    localparam int MODE_HI  = 6;
    localparam int MODE_LO  = 5;
    localparam int EXP_HI   = 4;
    localparam int EXP_LO   = 0;
    localparam logic [1:0] MODE_LINEAR = 2'h0;
    localparam logic [4:0] EXP_MIN     = 5'h14;   // -12
    localparam logic [4:0] EXP_MAX     = 5'h1C;   // -4
    localparam logic [7:0] VOUT_FORMAT_RESET = 8'h17;  // absolute, linear, -9
endpackage : amv_pkg
`default_nettype wire

// ### hdl/amv_rescale.sv
`timescale 1ns/1ps
`default_nettype none
// re-expresses a linear mantissa from one exponent to another
module amv_rescale (
    input  wire logic [15:0] value_in,
    input  wire logic [4:0]  exp_old,
    input  wire logic [4:0]  exp_new,
    output logic      [15:0] value_out
);
    logic signed [5:0] delta;

    always_comb begin
        delta = $signed({exp_old[4], exp_old}) - $signed({exp_new[4], exp_new});
        if (delta >= 0) begin
            value_out = value_in << delta[3:0];
        end else begin
            // finer to coarser: low bits are lost, truncation toward zero
            value_out = value_in >> 4'(-delta);
        end
    end
endmodule : amv_rescale
`default_nettype wire

// ### hdl/amv_alert_mask_and_vout_format.sv
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - mask bit 0 lets its condition raise alert; 1 blocks it
// - other-status mask reads 01h; first-alert mask fixed at 1, read-only
// - vendor mask via command 1Bh selector 80h; word write, process-call read
// - vendor mask writable bits 7,6,3,2,1; bits 5,4,0 read zero
// - clearing self-check mask may cause alert at power-up; keep it set
// - clearing sync-fault mask may briefly alert when stack enables
// - format register at 20h, byte write and byte read, nonvolatile backed
// - format byte: relative select bit 7, mode 6:5, exponent 4:0
// - relative select 0 means absolute data, 1 means relative
// - mode field fixed 00b linear; other modes unsupported and invalid
// - exponent two's complement, supported from -4 down to -12
// - format writes accepted only while conversion is disabled
// - format change rescales stored voltage values to new format
// - voltage writes decoded with current format, converted on later change
module amv_alert_mask_and_vout_format #(
    parameter logic [7:0] VENDOR_MASK_INIT = amv_pkg::VENDOR_MASK_RESET,
    parameter logic [7:0] VOUT_FORMAT_INIT = amv_pkg::VOUT_FORMAT_RESET
) (
    input  wire logic        mclk,
    input  wire logic        arst_n,
    input  wire logic        nvm_load,
    input  wire logic [7:0]  nvm_vendor_mask,
    input  wire logic [7:0]  nvm_vout_format,
    input  wire logic        wr_byte,
    input  wire logic        wr_word,
    input  wire logic        rd_byte,
    input  wire logic        rd_call,
    input  wire logic [7:0]  cmd_code,
    input  wire logic [7:0]  wr_lo,
    input  wire logic [7:0]  wr_hi,
    input  wire logic        conv_enabled,
    input  wire logic [7:0]  vendor_status_byte,
    input  wire logic        first_alert_flag,
    input  wire logic [15:0] conv_value_in,
    output logic      [7:0]  rd_data,
    output logic             rd_valid,
    output logic             rd_nack,
    output logic             wr_refused,
    output logic             alert_req,
    output logic      [7:0]  vendor_mask,
    output logic      [7:0]  vout_format,
    output logic             format_changed,
    output logic      [4:0]  exp_previous,
    output logic      [15:0] conv_value_out
);
    logic       fmt_write;
    logic       fmt_ok;
    logic [7:0] fmt_new;
    logic       vmask_write;
    logic       rd_any;
    logic [15:0] rescaled;
    logic [7:0] unmasked;

    assign fmt_new  = {wr_lo[amv_pkg::REL_BIT], amv_pkg::MODE_LINEAR,
                       wr_lo[amv_pkg::EXP_HI:amv_pkg::EXP_LO]};
    assign fmt_write = wr_byte && cmd_code == amv_pkg::CMD_VOUT_FORMAT;
    assign fmt_ok = !conv_enabled
        && wr_lo[amv_pkg::MODE_HI:amv_pkg::MODE_LO] == amv_pkg::MODE_LINEAR
        && $signed(wr_lo[4:0]) >= $signed(amv_pkg::EXP_MIN)
        && $signed(wr_lo[4:0]) <= $signed(amv_pkg::EXP_MAX);
    assign vmask_write = wr_word && cmd_code == amv_pkg::CMD_ALERT_MASK
        && wr_lo == amv_pkg::SEL_VENDOR;
    assign rd_any = rd_byte || rd_call;

    // vendor mask; only implemented bits store, the rest stay zero
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            vendor_mask <= VENDOR_MASK_INIT & amv_pkg::VENDOR_WRITABLE;
        end else if (nvm_load) begin
            vendor_mask <= nvm_vendor_mask & amv_pkg::VENDOR_WRITABLE;
        end else if (vmask_write) begin
            vendor_mask <= wr_hi & amv_pkg::VENDOR_WRITABLE;
        end
    end

    // format byte; mode bits are never stored from the host
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            vout_format <= VOUT_FORMAT_INIT;
        end else if (nvm_load) begin
            vout_format <= {nvm_vout_format[7], amv_pkg::MODE_LINEAR, nvm_vout_format[4:0]};
        end else if (fmt_write && fmt_ok) begin
            vout_format <= fmt_new;
        end
    end

    // change notice for the voltage-command store, with the old exponent
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            format_changed <= 1'b0;
            exp_previous   <= VOUT_FORMAT_INIT[amv_pkg::EXP_HI:amv_pkg::EXP_LO];
        end else begin
            format_changed <= fmt_write && fmt_ok && fmt_new != vout_format;
            if (fmt_write && fmt_ok) begin
                exp_previous <= vout_format[amv_pkg::EXP_HI:amv_pkg::EXP_LO];
            end
        end
    end

    // stored values were decoded with exp_previous; re-express them in the current one
    amv_rescale u_rescale (
        .value_in  (conv_value_in),
        .exp_old   (exp_previous),
        .exp_new   (vout_format[amv_pkg::EXP_HI:amv_pkg::EXP_LO]),
        .value_out (rescaled)
    );

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            conv_value_out <= 16'h0000;
        end else begin
            conv_value_out <= rescaled;
        end
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            wr_refused <= 1'b0;
        end else begin
            wr_refused <= fmt_write && !fmt_ok;
        end
    end

    // per-bit gating; self-check and sync-fault can glitch at power-up and stack
    // enable, and nothing here filters them: only a set mask bit keeps them quiet
    for (genvar b = 0; b < 8; b++) begin : g_unmask
        assign unmasked[b] = vendor_status_byte[b] && !vendor_mask[b]
                             && amv_pkg::VENDOR_WRITABLE[b];
    end

    // first-alert is always masked, so it never reaches the alert on its own
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            alert_req <= 1'b0;
        end else begin
            alert_req <= |unmasked
                || (first_alert_flag && !amv_pkg::OTHER_MASK_VALUE[0]);
        end
    end

    // read answers one cycle after the request
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            rd_data  <= 8'h00;
            rd_valid <= 1'b0;
            rd_nack  <= 1'b0;
        end else begin
            rd_valid <= 1'b0;
            rd_nack  <= 1'b0;
            if (rd_byte && cmd_code == amv_pkg::CMD_VOUT_FORMAT) begin
                rd_data  <= vout_format;
                rd_valid <= 1'b1;
            end else if (rd_call && cmd_code == amv_pkg::CMD_ALERT_MASK
                         && wr_lo == amv_pkg::SEL_VENDOR) begin
                rd_data  <= vendor_mask;
                rd_valid <= 1'b1;
            end else if (rd_call && cmd_code == amv_pkg::CMD_ALERT_MASK
                         && wr_lo == amv_pkg::SEL_OTHER_STATUS) begin
                rd_data  <= amv_pkg::OTHER_MASK_VALUE;
                rd_valid <= 1'b1;
            end else if (rd_any) begin
                rd_data  <= 8'h00;
                rd_nack  <= 1'b1;
            end
        end
    end

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!arst_n);

    AST_MASK_BLOCKS: assert property (
        (vendor_status_byte & ~vendor_mask & amv_pkg::VENDOR_WRITABLE) == 8'h00
        |=> !alert_req) else $error("masked condition raised alert");
    AST_UNMASKED_ALERTS: assert property (
        (vendor_status_byte & ~vendor_mask & amv_pkg::VENDOR_WRITABLE) != 8'h00
        |=> alert_req) else $error("unmasked condition did not alert");
    AST_OTHER_READ: assert property (
        rd_call && cmd_code == amv_pkg::CMD_ALERT_MASK && wr_lo == amv_pkg::SEL_OTHER_STATUS
        |=> rd_valid && rd_data == 8'h01) else $error("other mask read wrong");
    AST_VENDOR_WRITE: assert property (
        vmask_write && !nvm_load |=> vendor_mask == ($past(wr_hi) & 8'hCE))
        else $error("vendor mask write not stored");
    AST_VENDOR_ZEROS: assert property (
        (vendor_mask & 8'h31) == 8'h00) else $error("vendor fixed bits nonzero");
    AST_MODE_FIXED: assert property (
        vout_format[6:5] == 2'b00) else $error("mode field not linear");
    AST_LOCKED: assert property (
        conv_enabled && !nvm_load |=> $stable(vout_format))
        else $error("format changed while converting");
    AST_EXP_RANGE: assert property (
        fmt_write && !nvm_load && ($signed(wr_lo[4:0]) > -4 || $signed(wr_lo[4:0]) < -12)
        |=> $stable(vout_format) ##0 wr_refused) else $error("bad exponent accepted");
    AST_CHANGE_NOTICE: assert property (
        fmt_write && fmt_ok && !nvm_load && fmt_new != vout_format
        |=> format_changed && exp_previous == $past(vout_format[4:0]))
        else $error("format change not announced");
    AST_FORMAT_READ: assert property (
        rd_byte && cmd_code == amv_pkg::CMD_VOUT_FORMAT && !(wr_byte || nvm_load)
        |=> rd_valid && rd_data == vout_format) else $error("format read wrong");
    AST_SELF_CHECK_PASSES: assert property (
        vendor_status_byte[amv_pkg::SELF_CHECK_BIT] && !vendor_mask[amv_pkg::SELF_CHECK_BIT]
        |=> alert_req) else $error("unmasked self-check did not alert");
    AST_SYNC_FAULT_PASSES: assert property (
        vendor_status_byte[amv_pkg::SYNC_FAULT_BIT] && !vendor_mask[amv_pkg::SYNC_FAULT_BIT]
        |=> alert_req) else $error("unmasked sync fault did not alert");
    AST_REL_STORED: assert property (
        fmt_write && fmt_ok && !nvm_load
        |=> vout_format[amv_pkg::REL_BIT] == $past(wr_lo[amv_pkg::REL_BIT]))
        else $error("relative select not stored");
    AST_OTHER_WRITE_IGNORED: assert property (
        wr_word && cmd_code == amv_pkg::CMD_ALERT_MASK && wr_lo == amv_pkg::SEL_OTHER_STATUS
        && !nvm_load |=> $stable(vendor_mask)) else $error("fixed mask byte write took effect");
    AST_REFUSE_LOCKED: assert property (
        fmt_write && conv_enabled
        |=> wr_refused) else $error("locked format write not refused");
    AST_UNKNOWN_NACK: assert property (
        rd_byte && cmd_code != amv_pkg::CMD_VOUT_FORMAT
        |=> rd_nack && !rd_valid && rd_data == 8'h00) else $error("unknown read not refused");
endmodule : amv_alert_mask_and_vout_format
`default_nettype wire

// ### testbench/amv_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// host side of the command port; every move lands on a falling edge
module amv_host_model (
    input  wire logic       mclk,
    output logic            wr_byte,
    output logic            wr_word,
    output logic            rd_byte,
    output logic            rd_call,
    output logic      [7:0] cmd_code,
    output logic      [7:0] wr_lo,
    output logic      [7:0] wr_hi
);
    initial begin
        {rd_call, rd_byte, wr_word, wr_byte} = 4'h0;
        {cmd_code, wr_lo, wr_hi} = 24'h0;
    end
    // kind 0 byte write, 1 word write, 2 byte read, 3 process-call read
    task automatic xfer(input logic [1:0] kind, input logic [7:0] cmd,
                        input logic [7:0] lo, input logic [7:0] hi);
        @(negedge mclk);
        cmd_code = cmd;
        wr_lo = lo;
        wr_hi = hi;
        {rd_call, rd_byte, wr_word, wr_byte} = 4'h1 << kind;
        @(negedge mclk);
        {rd_call, rd_byte, wr_word, wr_byte} = 4'h0;
        // released fields must not look like a still-valid request
        {cmd_code, wr_lo, wr_hi} = ~{cmd, lo, hi};
    endtask : xfer
endmodule : amv_host_model
`default_nettype wire

// ### testbench/amv_alert_mask_and_vout_format_bench.sv
`timescale 1ns/1ps
`default_nettype none
module amv_alert_mask_and_vout_format_bench;
    logic mclk = 0, arst_n = 0, nvm_load = 0, conv_enabled = 0, first_alert_flag = 1;
    logic [7:0] nvm_vendor_mask = 8'hFF, nvm_vout_format = 8'hF4, vendor_status_byte = 8'h0;
    logic [15:0] conv_value_in = 16'h0, conv_value_out;
    logic wr_byte, wr_word, rd_byte, rd_call, rd_valid, rd_nack, wr_refused, alert_req;
    logic format_changed;
    logic [7:0] cmd_code, wr_lo, wr_hi, rd_data, vendor_mask, vout_format, d, cur;
    logic [4:0] exp_previous;
    logic ok;
    int error_cnt, num_checks, cyc;
    amv_host_model host (.mclk(mclk), .wr_byte(wr_byte), .wr_word(wr_word),
        .rd_byte(rd_byte), .rd_call(rd_call), .cmd_code(cmd_code), .wr_lo(wr_lo), .wr_hi(wr_hi));
    amv_alert_mask_and_vout_format uut (.mclk(mclk), .arst_n(arst_n), .nvm_load(nvm_load),
        .nvm_vendor_mask(nvm_vendor_mask), .nvm_vout_format(nvm_vout_format),
        .wr_byte(wr_byte), .wr_word(wr_word), .rd_byte(rd_byte), .rd_call(rd_call),
        .cmd_code(cmd_code), .wr_lo(wr_lo), .wr_hi(wr_hi), .conv_enabled(conv_enabled),
        .vendor_status_byte(vendor_status_byte), .first_alert_flag(first_alert_flag),
        .conv_value_in(conv_value_in), .rd_data(rd_data), .rd_valid(rd_valid),
        .rd_nack(rd_nack), .wr_refused(wr_refused), .alert_req(alert_req),
        .vendor_mask(vendor_mask), .vout_format(vout_format),
        .format_changed(format_changed), .exp_previous(exp_previous),
        .conv_value_out(conv_value_out));
    always #5 mclk = ~mclk;
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 5000) begin
            error_cnt++;
            give_verdict();
        end
    end
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string m);
        num_checks++;
        if (seen !== exp) begin
            $display("unexpected at %0t: %s", $time, m);
            error_cnt++;
        end
    endtask : chk
    task automatic give_verdict();
        if (error_cnt == 0 && num_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : give_verdict
    // truncates when coarsening, plain left shift when refining
    function automatic logic [15:0] resc(logic [15:0] v, logic [4:0] o, logic [4:0] n);
        int so = int'($signed(o));
        int sn = int'($signed(n));
        return (so > sn) ? v << (so - sn) : v >> (sn - so);
    endfunction : resc
    initial begin
        void'($urandom(78));
        repeat (3) @(negedge mclk);
        arst_n = 1;
        nvm_load = 1;
        @(negedge mclk);
        nvm_load = 0;
        chk(vendor_mask, 8'hCE, "nvm mask");
        chk(vout_format, 8'h94, "nvm format");
        host.xfer(1, 8'h1B, 8'h7F, 8'h00);
        host.xfer(3, 8'h1B, 8'h7F, 8'h00);
        chk({rd_valid, rd_data}, 9'h101, "other mask");
        for (int i = 0; i < 9; i++) begin
            d = (i == 8) ? 8'h00 : 8'($urandom);
            host.xfer(1, 8'h1B, 8'h80, d);
            host.xfer(3, 8'h1B, 8'h80, 8'h00);
            chk({rd_valid, rd_data}, {1'b1, d & 8'hCE}, "vendor mask");
        end
        host.xfer(3, 8'h1B, 8'h7D, 8'h00);
        chk({rd_nack, rd_data}, 9'h100, "bad selector");
        for (int i = 0; i < 9; i++) begin
            vendor_status_byte = (i == 8) ? 8'h00 : 8'h01 << i;
            @(negedge mclk);
            chk(alert_req, ((8'h01 << i) & 8'hCE) != 0 && i < 8, "alert");
        end
        host.xfer(1, 8'h1B, 8'h80, 8'hCE);
        vendor_status_byte = 8'hFF;
        @(negedge mclk);
        chk(alert_req, 1'b0, "masked alert");
        for (int i = 0; i < 24; i++) begin
            d = (i < 9) ? 8'(72'h94171C001413BC181D >> (8 * i)) : 8'($urandom);
            cur = vout_format;
            conv_enabled = (i == 1) || (i >= 9 && $urandom % 5 == 0);
            conv_value_in = 16'($urandom);
            ok = !conv_enabled && d[6:5] == 2'h0 && d[4:0] >= 5'h14 && d[4:0] <= 5'h1C;
            host.xfer(0, 8'h20, d, 8'h00);
            chk(vout_format, ok ? d : cur, "format");
            chk({wr_refused, format_changed}, {!ok, ok && d != cur}, "flags");
            if (ok) chk(exp_previous, cur[4:0], "old exponent");
            @(negedge mclk);
            if (ok) chk(conv_value_out, resc(conv_value_in, cur[4:0], d[4:0]), "rescale");
            host.xfer(2, 8'h20, 8'h00, 8'h00);
            chk({rd_valid, rd_data}, {1'b1, ok ? d : cur}, "format read");
        end
        host.xfer(2, 8'h21, 8'h00, 8'h00);
        chk({rd_nack, rd_data}, 9'h100, "unknown read");
        give_verdict();
    end
endmodule : amv_alert_mask_and_vout_format_bench
`default_nettype wire
